/* File: core/cca_txirq.sv */
// channel assessment control and transmit byte count comparator
//
// How it works
// [RQ1] flag when moved byte count equals threshold
// [RQ2] new threshold applies after old one fires
// [RQ3] software writes zero to threshold bits 15:12
// [RQ4] threshold resets to sixteen bytes
// [RQ5] criterion zero compares power against threshold
// [RQ6] criterion one uses carrier sense only
// [RQ7] criterion two ors, three ands both
// [RQ8] continuous mode repeats, refreshes verdict and energy
// [RQ9] stop command or clear channel ends assessment
// [RQ10] software uses continuation only with power criterion
// [RQ11] software keeps continuation apart from other modes
// [RQ12] count select stops at the repetition limit
// [RQ13] signal during assessment switches to reception
// [RQ14] software avoids mixing mid reception modes
// [RQ15] mid reception start raises completion flag
// [RQ16] cancelled reception flags and returns idle
// [RQ17] control holds receive, select, enable, criterion
// [RQ18] control register resets to zero
// [RQ19] flags set only when enabled
// [RQ20] byte counter clears at each frame start
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module cca_txirq (
  // clock and reset
  input  wire logic                                sys_clk_i,
  input  wire logic                                sys_rst_i,
  // apb slave
  input  wire logic                                psel_i,
  input  wire logic                                penable_i,
  input  wire logic                                pwrite_i,
  input  wire logic [cca_txirq_pkg::ADDR_W-1:0]    paddr_i,
  input  wire logic [cca_txirq_pkg::DATA_W-1:0]    pwdata_i,
  output logic      [cca_txirq_pkg::DATA_W-1:0]    prdata_o,
  output logic                                     pready_o,
  output logic                                     pslverr_o,
  // rf front end
  input  wire cca_txirq_pkg::fe_in_t               fe_i,
  // status toward the rest of the baseband
  output logic      [cca_txirq_pkg::FLG_W-1:0]     flags_o,
  output logic                                     cca_active_o,
  output logic                                     rx_active_o,
  output logic                                     channel_busy_o
);

  // synchronised front end and previous sample for edges
  cca_txirq_pkg::fe_in_t fe_s;
  cca_txirq_pkg::fe_in_t fe_p_q;

  fe_sync #(
    .W ($bits(cca_txirq_pkg::fe_in_t))
  ) u_fe_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (fe_i),
    .q_o       (fe_s)
  );

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fe_p_q <= '0;
    end else begin
      fe_p_q <= fe_s;
    end
  end

  // rising edges of the synchronised indications
  wire ed_evt     = fe_s.power_valid & ~fe_p_q.power_valid;
  wire sig_evt    = fe_s.sig_detect  & ~fe_p_q.sig_detect;
  wire cancel_evt = fe_s.rx_cancel   & ~fe_p_q.rx_cancel;
  wire done_evt   = fe_s.rx_done     & ~fe_p_q.rx_done;
  wire byte_evt   = fe_s.tx_byte     & ~fe_p_q.tx_byte;
  wire start_evt  = fe_s.tx_start    & ~fe_p_q.tx_start;
  wire end_evt    = fe_s.tx_end      & ~fe_p_q.tx_end;

  // registers
  logic [cca_txirq_pkg::THR_W-1:0] thr_q;
  logic [cca_txirq_pkg::CTL_W-1:0] ctl_q;
  logic [cca_txirq_pkg::PWR_W-1:0] pthr_q;
  logic [cca_txirq_pkg::PWR_W-1:0] limit_q;
  logic [cca_txirq_pkg::FLG_W-1:0] en_q;
  logic [cca_txirq_pkg::FLG_W-1:0] flags_q;
  logic [cca_txirq_pkg::FLG_W-1:0] flags_d;
  logic                            pready_q;
  logic                            pslverr_q;
  logic [cca_txirq_pkg::DATA_W-1:0] prdata_q;

  // apb decode
  wire [cca_txirq_pkg::IDX_W-1:0] idx = paddr_i[cca_txirq_pkg::ADDR_W-1:2];
  wire aligned   = (paddr_i[1:0] == 2'h0);
  wire hit_thr   = aligned & (idx == cca_txirq_pkg::IDX_TX_THR);
  wire hit_ctl   = aligned & (idx == cca_txirq_pkg::IDX_CCA_CTL);
  wire hit_pthr  = aligned & (idx == cca_txirq_pkg::IDX_PWR_THR);
  wire hit_limit = aligned & (idx == cca_txirq_pkg::IDX_LIMIT);
  wire hit_cmd   = aligned & (idx == cca_txirq_pkg::IDX_COMMAND);
  wire hit_stat  = aligned & (idx == cca_txirq_pkg::IDX_STATUS);
  wire hit_flags = aligned & (idx == cca_txirq_pkg::IDX_FLAGS);
  wire hit_en    = aligned & (idx == cca_txirq_pkg::IDX_ENABLES);
  wire hit_nrg   = aligned & (idx == cca_txirq_pkg::IDX_ENERGY);
  wire mapped    = hit_thr | hit_ctl | hit_pthr | hit_limit | hit_cmd
                 | hit_stat | hit_flags | hit_en | hit_nrg;
  wire setup     = psel_i & ~penable_i;
  wire wr_fire   = psel_i & penable_i & pready_q & pwrite_i & mapped;

  // command strobes
  wire start_cmd = wr_fire & hit_cmd & pwdata_i[cca_txirq_pkg::CMD_START_BIT];
  wire stop_cmd  = wr_fire & hit_cmd & pwdata_i[cca_txirq_pkg::CMD_STOP_BIT];

  // control fields
  wire cca_txirq_pkg::crit_t crit = cca_txirq_pkg::crit_t'(ctl_q[cca_txirq_pkg::CTL_CRIT_LSB +: 2]);
  wire cont = ctl_q[cca_txirq_pkg::CTL_CEN_BIT];   // RQ17
  wire csel = ctl_q[cca_txirq_pkg::CTL_CSEL_BIT];  // RQ17
  wire rxen = ctl_q[cca_txirq_pkg::CTL_RXEN_BIT];  // RQ17

  // transmit byte comparator state
  logic [cca_txirq_pkg::THR_W-1:0] byte_cnt_q;
  logic [cca_txirq_pkg::THR_W-1:0] act_thr_q;
  logic                            tx_busy_q;
  wire  [cca_txirq_pkg::THR_W-1:0] cnt_inc = byte_cnt_q + cca_txirq_pkg::CNT_ONE;
  wire  tx_fire = byte_evt & tx_busy_q & (cnt_inc == act_thr_q);  // RQ1

  // assessment state
  cca_txirq_pkg::cca_state_t       state_q;
  cca_txirq_pkg::cca_state_t       state_d;
  logic [cca_txirq_pkg::PWR_W-1:0] rep_q;
  logic                            judge_q;
  logic [cca_txirq_pkg::PWR_W-1:0] ed1_q;
  logic [cca_txirq_pkg::PWR_W-1:0] ed2_q;

  // channel verdict under the selected criterion
  wire pwr_hi  = (fe_s.power >= pthr_q);                                  // RQ5
  wire busy_w  = cca_txirq_pkg::chan_busy(crit, pwr_hi, fe_s.carrier);   // RQ6 RQ7
  wire [cca_txirq_pkg::PWR_W-1:0] rep_inc = rep_q + cca_txirq_pkg::REP_ONE;

  // decisions taken while assessing or receiving
  wire in_assess  = (state_q == cca_txirq_pkg::ST_ASSESS);
  wire in_receive = (state_q == cca_txirq_pkg::ST_RECEIVE);
  wire pass_end   = in_assess & ed_evt & ~stop_cmd;
  wire mid_go     = in_assess & ~stop_cmd & rxen & sig_evt;               // RQ13
  wire limit_hit  = cont & csel & (rep_inc >= limit_q);                   // RQ12
  wire pass_stop  = pass_end & ~mid_go & (~cont | ~busy_w | limit_hit);   // RQ8 RQ9
  wire rx_cancel  = in_receive & cancel_evt;

  // events that may raise a flag
  wire [cca_txirq_pkg::FLG_W-1:0] ev;
  assign ev[cca_txirq_pkg::FLG_TX]      = tx_fire;
  assign ev[cca_txirq_pkg::FLG_DONE]    = pass_stop | mid_go;              // RQ15
  assign ev[cca_txirq_pkg::FLG_CLR]     = (pass_stop & ~busy_w) | rx_cancel;  // RQ16
  assign ev[cca_txirq_pkg::FLG_LIMIT]   = pass_stop & busy_w & limit_hit;
  assign ev[cca_txirq_pkg::FLG_RXSTART] = mid_go;

  // sticky flags, write one to clear, a new event beats the clear
  wire [cca_txirq_pkg::FLG_W-1:0] clr = (wr_fire & hit_flags) ? pwdata_i[cca_txirq_pkg::FLG_W-1:0]
                                                              : cca_txirq_pkg::FLG_RST;
  assign flags_d = (flags_q & ~clr) | (ev & en_q);  // RQ19

  // sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cca_txirq_pkg::ST_IDLE: begin
        if (start_cmd) begin
          state_d = cca_txirq_pkg::ST_ASSESS;
        end
      end
      cca_txirq_pkg::ST_ASSESS: begin
        if (stop_cmd) begin
          state_d = cca_txirq_pkg::ST_IDLE;     // RQ9
        end else if (mid_go) begin
          state_d = cca_txirq_pkg::ST_RECEIVE;  // RQ13
        end else if (pass_stop) begin
          state_d = cca_txirq_pkg::ST_IDLE;     // RQ9 RQ12
        end
      end
      cca_txirq_pkg::ST_RECEIVE: begin
        if (stop_cmd | cancel_evt | done_evt) begin
          state_d = cca_txirq_pkg::ST_IDLE;     // RQ16
        end
      end
      default: state_d = cca_txirq_pkg::ST_IDLE;
    endcase
  end

  // read data selection
  logic [cca_txirq_pkg::DATA_W-1:0] rd_data;
  always_comb begin
    rd_data = '0;
    if (hit_thr) begin
      rd_data = {20'h00000, thr_q};
    end else if (hit_ctl) begin
      rd_data = {27'h0000000, ctl_q};
    end else if (hit_pthr) begin
      rd_data = {24'h000000, pthr_q};
    end else if (hit_limit) begin
      rd_data = {24'h000000, limit_q};
    end else if (hit_stat) begin
      // tx count, repetitions, tx busy, receive, assess, verdict
      rd_data = {4'h0, byte_cnt_q, rep_q, 4'h0, tx_busy_q, rx_active_o, cca_active_o, judge_q};
    end else if (hit_flags) begin
      rd_data = {27'h0000000, flags_q};
    end else if (hit_en) begin
      rd_data = {27'h0000000, en_q};
    end else if (hit_nrg) begin
      rd_data = {16'h0000, ed2_q, ed1_q};
    end
  end

  // apb answer: ready in the access phase after every setup
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= (setup & ~pwrite_i) ? rd_data : '0;
    end
  end

  // software written registers
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      thr_q   <= cca_txirq_pkg::THR_RST;    // RQ4
      ctl_q   <= cca_txirq_pkg::CTL_RST;    // RQ18
      pthr_q  <= cca_txirq_pkg::PWR_RST;
      limit_q <= cca_txirq_pkg::LIMIT_RST;
      en_q    <= cca_txirq_pkg::FLG_RST;
      flags_q <= cca_txirq_pkg::FLG_RST;
    end else begin
      if (wr_fire & hit_thr) thr_q <= pwdata_i[cca_txirq_pkg::THR_W-1:0];
      if (wr_fire & hit_ctl) ctl_q <= pwdata_i[cca_txirq_pkg::CTL_W-1:0];
      if (wr_fire & hit_pthr) pthr_q <= pwdata_i[cca_txirq_pkg::PWR_W-1:0];
      if (wr_fire & hit_limit) limit_q <= pwdata_i[cca_txirq_pkg::PWR_W-1:0];
      if (wr_fire & hit_en) en_q <= pwdata_i[cca_txirq_pkg::FLG_W-1:0];
      flags_q <= flags_d;
    end
  end

  // byte counter per frame and the threshold in force
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byte_cnt_q <= '0;
      tx_busy_q  <= 1'b0;
      act_thr_q  <= cca_txirq_pkg::THR_RST;
    end else begin
      if (start_evt) begin
        byte_cnt_q <= '0;      // RQ20
      end else if (byte_evt) begin
        byte_cnt_q <= cnt_inc;
      end
      if (start_evt) begin
        tx_busy_q <= 1'b1;
      end else if (end_evt) begin
        tx_busy_q <= 1'b0;
      end
      if (~tx_busy_q | tx_fire) begin
        act_thr_q <= thr_q;    // RQ2
      end
    end
  end

  // sequencer, repetition count, verdict and energy results
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= cca_txirq_pkg::ST_IDLE;
      rep_q   <= '0;
      judge_q <= 1'b0;
      ed1_q   <= cca_txirq_pkg::PWR_RST;
      ed2_q   <= cca_txirq_pkg::PWR_RST;
    end else begin
      state_q <= state_d;
      if (start_cmd & ~in_assess) begin
        rep_q <= '0;
        ed2_q <= cca_txirq_pkg::PWR_RST;
      end else if (pass_end) begin
        rep_q   <= rep_inc;
        judge_q <= busy_w;                                    // RQ8
        ed1_q   <= fe_s.power;                                // RQ8
        ed2_q   <= (fe_s.power > ed2_q) ? fe_s.power : ed2_q; // RQ8
      end
    end
  end

  // outputs, all from flip-flops
  assign prdata_o       = prdata_q;
  assign pready_o       = pready_q;
  assign pslverr_o      = pslverr_q;
  assign flags_o        = flags_q;
  assign cca_active_o   = state_q[cca_txirq_pkg::ASSESS_IX];
  assign rx_active_o    = state_q[cca_txirq_pkg::RECEIVE_IX];
  assign channel_busy_o = judge_q;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_tx_byte_fire: assert property (byte_evt && tx_busy_q && !start_evt && cnt_inc == act_thr_q // RQ1
    && en_q[cca_txirq_pkg::FLG_TX] |=> flags_q[cca_txirq_pkg::FLG_TX])
    else $error("byte count match did not raise the flag");

  a_thr_held_busy: assert property (tx_busy_q && !tx_fire |=> $stable(act_thr_q)) // RQ2
    else $error("threshold changed during frame before firing");

  a_crit_power: assert property (pass_end && crit == cca_txirq_pkg::CRIT_POWER // RQ5
    |=> judge_q == $past(pwr_hi))
    else $error("power criterion verdict wrong");

  a_crit_carrier: assert property (pass_end && crit == cca_txirq_pkg::CRIT_CARRIER // RQ6
    |=> judge_q == $past(fe_s.carrier))
    else $error("carrier criterion verdict wrong");

  a_crit_combine: assert property (pass_end && crit == cca_txirq_pkg::CRIT_AND // RQ7
    |=> judge_q == ($past(pwr_hi) && $past(fe_s.carrier)))
    else $error("and criterion verdict wrong");

  a_cont_repeat: assert property (pass_end && !mid_go && cont && !csel && busy_w // RQ8
    |=> cca_active_o && ed1_q == $past(fe_s.power))
    else $error("continuous assessment stopped while busy");

  a_stop_clear: assert property ((pass_end && !mid_go && !busy_w) || (in_assess && stop_cmd) // RQ9
    |=> !cca_active_o)
    else $error("assessment did not end");

  a_limit_stop: assert property (pass_end && !mid_go && cont && csel && rep_inc >= limit_q // RQ12
    |=> !cca_active_o && rep_q == $past(rep_inc))
    else $error("limit did not stop assessment");

  a_mid_receive: assert property (mid_go && en_q[cca_txirq_pkg::FLG_DONE] // RQ13 RQ15
    |=> rx_active_o && flags_q[cca_txirq_pkg::FLG_DONE])
    else $error("mid assessment reception not started");

  a_cancel_idle: assert property (rx_cancel |=> !rx_active_o && !cca_active_o) // RQ16
    else $error("cancelled reception did not return idle");

  a_flag_gate: assert property ((flags_q & ~$past(flags_q) & ~$past(en_q)) == '0) // RQ19
    else $error("flag set while its enable was low");

  a_count_clear: assert property (start_evt |=> byte_cnt_q == '0) // RQ20
    else $error("byte counter not cleared at frame start");

  c_tx_fire:   cover property (tx_fire ##1 flags_q[cca_txirq_pkg::FLG_TX]);
  c_cont_loop: cover property (pass_end && cont && busy_w ##[1:50] pass_end && !busy_w);
  c_mid_rx:    cover property (mid_go ##[1:50] rx_cancel);

endmodule

/* File: core/fe_sync.sv */
// two flip-flop synchroniser for the front end indications
`timescale 1ns/10ps
module fe_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

/* File: shared/cca_txirq_pkg.sv */
// constants, types and register map of the assessment and transmit byte block
package cca_txirq_pkg;

  // apb geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TX_THR   = 10'h116;
  localparam logic [IDX_W-1:0] IDX_CCA_CTL  = 10'h118;
  localparam logic [IDX_W-1:0] IDX_PWR_THR  = 10'h120;
  localparam logic [IDX_W-1:0] IDX_LIMIT    = 10'h121;
  localparam logic [IDX_W-1:0] IDX_COMMAND  = 10'h122;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 10'h123;
  localparam logic [IDX_W-1:0] IDX_FLAGS    = 10'h124;
  localparam logic [IDX_W-1:0] IDX_ENABLES  = 10'h125;
  localparam logic [IDX_W-1:0] IDX_ENERGY   = 10'h126;

  // transmit byte threshold: twelve live bits, reset to sixteen
  localparam int unsigned        THR_W   = 12;
  localparam logic [THR_W-1:0]   THR_RST = 12'h010;

  // assessment control layout and reset
  localparam int unsigned        CTL_W        = 5;
  localparam logic [CTL_W-1:0]   CTL_RST      = 5'h00;
  localparam int unsigned        CTL_CRIT_LSB = 0;
  localparam int unsigned        CTL_CEN_BIT  = 2;
  localparam int unsigned        CTL_CSEL_BIT = 3;
  localparam int unsigned        CTL_RXEN_BIT = 4;

  // command register bits, write one to act
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT  = 1;

  // event flag and enable layout
  localparam int unsigned      FLG_W       = 5;
  localparam int unsigned      FLG_TX      = 0;
  localparam int unsigned      FLG_DONE    = 1;
  localparam int unsigned      FLG_CLR     = 2;
  localparam int unsigned      FLG_LIMIT   = 3;
  localparam int unsigned      FLG_RXSTART = 4;
  localparam logic [FLG_W-1:0] FLG_RST     = 5'h00;

  // power, limit and counter widths with resets
  localparam int unsigned        PWR_W     = 8;
  localparam logic [PWR_W-1:0]   PWR_RST   = 8'h00;
  localparam logic [PWR_W-1:0]   LIMIT_RST = 8'h00;
  localparam logic [THR_W-1:0]   CNT_ONE   = 12'h001;
  localparam logic [PWR_W-1:0]   REP_ONE   = 8'h01;

  // detection criterion
  typedef enum logic [1:0] {
    CRIT_POWER   = 2'h0,
    CRIT_CARRIER = 2'h1,
    CRIT_OR      = 2'h2,
    CRIT_AND     = 2'h3
  } crit_t;

  // assessment sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_ASSESS  = 3'h2,
    ST_RECEIVE = 3'h4
  } cca_state_t;
  localparam int unsigned ASSESS_IX  = 1;
  localparam int unsigned RECEIVE_IX = 2;

  // indications from the rf front end
  typedef struct packed {
    logic [PWR_W-1:0] power;
    logic             power_valid;
    logic             carrier;
    logic             sig_detect;
    logic             rx_cancel;
    logic             rx_done;
    logic             tx_byte;
    logic             tx_start;
    logic             tx_end;
  } fe_in_t;

  // channel busy verdict for a criterion
  function automatic logic chan_busy(input crit_t crit, input logic pwr_hi, input logic carrier);
    logic b;
    b = 1'b0;
    unique case (crit)
      CRIT_POWER:   b = pwr_hi;
      CRIT_CARRIER: b = carrier;
      CRIT_OR:      b = pwr_hi | carrier;
      CRIT_AND:     b = pwr_hi & carrier;
    endcase
    return b;
  endfunction

endpackage

/* File: testbench/cca_txirq_tb.sv */
// self-checking bench of the assessment and transmit byte block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module cca_txirq_tb;
  // register indices and event positions
  localparam logic [9:0] THR = cca_txirq_pkg::IDX_TX_THR;
  localparam logic [9:0] CTL = cca_txirq_pkg::IDX_CCA_CTL;
  localparam logic [9:0] CMD = cca_txirq_pkg::IDX_COMMAND;
  localparam logic [9:0] FLG = cca_txirq_pkg::IDX_FLAGS;
  localparam logic [9:0] ENA = cca_txirq_pkg::IDX_ENABLES;
  localparam int PV = 7;
  localparam int SIG = 5;
  localparam int CAN = 4;
  localparam int DON = 3;
  localparam int TXB = 2;
  localparam int TXS = 1;
  localparam int TXE = 0;
  // design signals
  logic                  sys_clk_i = 1'b0;
  logic                  sys_rst_i = 1'b1;
  logic                  psel_i    = 1'b0;
  logic                  penable_i = 1'b0;
  logic                  pwrite_i  = 1'b0;
  logic [11:0]           paddr_i   = 12'h000;
  logic [31:0]           pwdata_i  = 32'h0000_0000;
  logic [31:0]           prdata_o;
  logic                  pready_o;
  logic                  pslverr_o;
  cca_txirq_pkg::fe_in_t fe_i;
  logic [4:0]            flags_o;
  logic                  cca_active_o;
  logic                  rx_active_o;
  logic                  channel_busy_o;
  // bench state and reference model
  int                    fail_count   = 0;
  int                    total_checks = 0;
  int                    cyc          = 0;
  int                    cnt;
  int                    thr_now;
  int                    pend_q[$];
  logic                  exp_flag;
  logic                  b;
  logic [15:0]           lfsr_q = 16'h0023;
  logic [31:0]           rd_q;
  logic                  err_q;

  cca_txirq u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .fe_i(fe_i), .flags_o(flags_o), .cca_active_o(cca_active_o),
    .rx_active_o(rx_active_o), .channel_busy_o(channel_busy_o));
  fe_model u_fe (.sys_clk_i(sys_clk_i), .fe_o(fe_i));

  // clock and hang guard
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [9:0] ix, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= {ix, 2'b00};
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [9:0] ix, input logic [31:0] ex);
    apb(1'b0, ix, 32'h0000_0000);
    `CHK(nm, ex, rd_q)
  endtask

  // one moved byte against the reference counter
  task automatic tx_byte(input logic en);
    u_fe.pulse(TXB);
    cnt++;
    if (en && cnt == thr_now) begin
      exp_flag = 1'b1;
      if (pend_q.size() > 0) thr_now = pend_q.pop_front();
    end
    `CHK("tx flag", exp_flag, flags_o[cca_txirq_pkg::FLG_TX])
  endtask

  task automatic clr();
    apb(1'b1, FLG, 32'h0000_001F);
    exp_flag = 1'b0;
  endtask

  task automatic start(input logic [31:0] c, input logic [7:0] pwr);
    clr();
    apb(1'b1, CTL, c);
    u_fe.set_level(pwr, 1'b0);
    apb(1'b1, CMD, 32'h0000_0001);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // reset values, random read back, unmapped place
    rchk("thr reset", THR, 32'h0000_0010);
    rchk("ctl reset", CTL, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      apb(1'b1, THR, {20'h0, lfsr_q[11:0]});
      apb(1'b1, CTL, {27'h0, lfsr_q[15:11]});
      rchk("thr rw", THR, {20'h0, lfsr_q[11:0]});
      rchk("ctl rw", CTL, {27'h0, lfsr_q[15:11]});
    end
    apb(1'b0, 10'h119, 32'h0000_0000);
    `CHK("unmapped", 1'b1, err_q)
    $display("test registers done");
    // byte threshold rewritten in mid frame, then a masked frame
    apb(1'b1, CTL, 32'h0000_0000);
    apb(1'b1, ENA, 32'h0000_001F);
    apb(1'b1, THR, 32'h0000_0002);
    clr();
    thr_now = 2;
    cnt = 0;
    u_fe.pulse(TXS);
    tx_byte(1'b1);
    apb(1'b1, THR, 32'h0000_0004);
    pend_q.push_back(4);
    tx_byte(1'b1);
    clr();
    tx_byte(1'b1);
    tx_byte(1'b1);
    u_fe.pulse(TXE);
    clr();
    apb(1'b1, ENA, 32'h0000_001E);
    cnt = 0;
    u_fe.pulse(TXS);
    for (int i = 0; i < 4; i++) tx_byte(1'b0);
    u_fe.pulse(TXE);
    $display("test tx bytes done");
    // every criterion against power at the threshold edge and carrier
    apb(1'b1, ENA, 32'h0000_001F);
    apb(1'b1, cca_txirq_pkg::IDX_PWR_THR, 32'h0000_0080);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, CTL, c);
        u_fe.set_level(k[0] ? 8'h80 : 8'h7F, k[1]);
        apb(1'b1, CMD, 32'h0000_0001);
        u_fe.pulse(PV);
        case (c)
          0: b = k[0];
          1: b = k[1];
          2: b = k[0] | k[1];
          default: b = k[0] & k[1];
        endcase
        `CHK("verdict", b, channel_busy_o)
        `CHK("one pass", 1'b0, cca_active_o)
      end
    end
    $display("test criteria done");
    // continuation: refresh, stop command, clear channel, limit
    start(32'h0000_0004, 8'hC0);
    u_fe.pulse(PV);
    u_fe.set_level(8'hD3, 1'b0);
    u_fe.pulse(PV);
    `CHK("repeats", 1'b1, cca_active_o)
    rchk("energy", cca_txirq_pkg::IDX_ENERGY, 32'h0000_D3D3);
    apb(1'b1, CMD, 32'h0000_0002);
    repeat (3) @(posedge sys_clk_i);
    `CHK("stopped", 1'b0, cca_active_o)
    start(32'h0000_0004, 8'h10);
    u_fe.pulse(PV);
    `CHK("clear end", 1'b0, cca_active_o)
    `CHK("clear flag", 1'b1, flags_o[cca_txirq_pkg::FLG_CLR])
    start(32'h0000_0004, 8'hC0);
    u_fe.pulse(PV);
    `CHK("busy holds", 1'b1, cca_active_o)
    u_fe.set_level(8'h10, 1'b0);
    u_fe.pulse(PV);
    `CHK("late clear", 1'b0, cca_active_o)
    apb(1'b1, cca_txirq_pkg::IDX_LIMIT, 32'h0000_0002);
    start(32'h0000_000C, 8'hC0);
    u_fe.pulse(PV);
    `CHK("below limit", 1'b1, cca_active_o)
    u_fe.pulse(PV);
    `CHK("limit end", 1'b0, cca_active_o)
    `CHK("limit flag", 1'b1, flags_o[cca_txirq_pkg::FLG_LIMIT])
    $display("test continuation done");
    // reception during assessment, then cancelled, then ended by done
    start(32'h0000_0010, 8'hC0);
    u_fe.pulse(SIG);
    `CHK("rx on", 1'b1, rx_active_o)
    `CHK("cca off", 1'b0, cca_active_o)
    `CHK("done flag", 1'b1, flags_o[cca_txirq_pkg::FLG_DONE])
    `CHK("rx flag", 1'b1, flags_o[cca_txirq_pkg::FLG_RXSTART])
    u_fe.pulse(CAN);
    `CHK("rx off", 1'b0, rx_active_o)
    `CHK("cancel flag", 1'b1, flags_o[cca_txirq_pkg::FLG_CLR])
    start(32'h0000_0010, 8'hC0);
    u_fe.pulse(SIG);
    `CHK("rx again", 1'b1, rx_active_o)
    u_fe.pulse(DON);
    `CHK("rx done", 1'b0, rx_active_o)
    $display("test mid reception done");
    print_verdict();
  end
endmodule

/* File: testbench/fe_model.sv */
// behavioural rf front end driving the indication bundle
`timescale 1ns/10ps
module fe_model (
  // clock
  input  wire logic            sys_clk_i,
  // indications
  output cca_txirq_pkg::fe_in_t fe_o
);
  // quiet front end from time zero
  initial fe_o = '0;

  // one event: held three clocks high and three low to pass the synchroniser
  task automatic pulse(input int ix);
    @(posedge sys_clk_i);
    fe_o[ix] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    fe_o[ix] <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // power settles well before the next valid strobe
  task automatic set_level(input logic [7:0] pwr, input logic car);
    @(posedge sys_clk_i);
    fe_o.power   <= pwr;
    fe_o.carrier <= car;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule
